/* rtl/heof_pkg.sv */
`default_nettype none
package heof_pkg;

	// frame lengths in bit times
	localparam logic [15:0] HEOF_FRAME_HS    = 16'hEA60;
	localparam logic [15:0] HEOF_FRAME_FS    = 16'h2EE0;
	// rollover tests of the current-frame counter
	localparam logic [15:0] HEOF_ROLL_HS     = 16'hFFFF;
	localparam logic [15:0] HEOF_ROLL_FS     = 16'h3FFF;
	// eof points, bit times before the end of the frame
	localparam logic [15:0] HEOF_EOF1_HS     = 16'h0230;
	localparam logic [15:0] HEOF_EOF2_HS     = 16'h0040;
	localparam logic [15:0] HEOF_EOF1_FS     = 16'h0020;
	localparam logic [15:0] HEOF_EOF2_FS     = 16'h000A;
	// sof decode and reaction advance, least figures
	localparam logic [15:0] HEOF_ADV_HS      = 16'h0028;
	localparam logic [15:0] HEOF_ADV_FS      = 16'h0010;
	// forced upstream eop length in full-speed bit times
	localparam logic [2:0]  HEOF_EOP_BITS    = 3'h4;
	// missed sofs tolerated before lock is dropped
	localparam logic [1:0]  HEOF_MISS_MAX    = 2'h2;
	// values after reset
	localparam logic [15:0] HEOF_TMR_RST     = 16'h0000;
	localparam logic [1:0]  HEOF_MISS_RST    = 2'h0;
	localparam logic [2:0]  HEOF_EOP_RST     = 3'h0;

endpackage : heof_pkg
`default_nettype wire

/* rtl/heof_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface heof_if;
	// host to hub
	logic sof;
	logic hs;
	logic dn_busy;
	// hub to host
	logic up_conn;
	logic up_eop;

	modport host
	(
		output sof,
		output hs,
		output dn_busy,
		input  up_conn,
		input  up_eop
	);

	modport hub
	(
		input  sof,
		input  hs,
		input  dn_busy,
		output up_conn,
		output up_eop
	);
endinterface : heof_if
`default_nettype wire

/* rtl/heof_hub.sv */
`timescale 1ns/1ps
`default_nettype none
module heof_hub
	import heof_pkg::*;
#(
	parameter logic [15:0] ADV_HS   = HEOF_ADV_HS,
	parameter logic [15:0] ADV_FS   = HEOF_ADV_FS,
	parameter bit          EOP_IDLE = 1'b1
)
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	// link toward the host
	heof_if.hub       lnk,
	// downstream port side
	input  wire logic i_resume,
	input  wire logic i_dn_active,
	input  wire logic i_ebuf_empty,
	input  wire logic i_port_reenable,
	// status
	output logic      o_locked,
	output logic      o_eof1,
	output logic      o_eof2,
	output logic      o_conn,
	output logic      o_babble,
	output logic      o_port_disabled
);

	typedef struct packed {
		logic [15:0] cur;
		logic [15:0] nxt;
		logic [15:0] tmr;
		logic        rolled;
		logic        seen_one;
		logic        sof_since;
		logic        locked;
		logic [1:0]  miss;
		logic        zone;
		logic        conn;
		logic [2:0]  eop_cnt;
		logic        eop;
		logic        eof1;
		logic        eof2;
		logic        babble;
		logic        port_dis;
	} heof_hub_s;

	heof_hub_s q;
	heof_hub_s next_q;

	logic [15:0] roll_lim;
	logic [15:0] eof1_pt;
	logic [15:0] eof2_pt;
	logic        hit1;
	logic        hit2;
	logic        reload;
	logic        conn_ok;

	// speed-selected compare points, advanced by the decode delay
	always_comb
	begin
		roll_lim = lnk.hs ? HEOF_ROLL_HS : HEOF_ROLL_FS;
		eof1_pt  = lnk.hs ? 16'(HEOF_EOF1_HS + ADV_HS)
		                  : 16'(HEOF_EOF1_FS + ADV_FS);
		eof2_pt  = lnk.hs ? 16'(HEOF_EOF2_HS + ADV_HS)
		                  : 16'(HEOF_EOF2_FS + ADV_FS);
	end

	// points carry no meaning until locked to sof
	assign hit1    = q.locked && (q.tmr == eof1_pt);
	assign hit2    = q.locked && (q.tmr == eof2_pt);
	// timer counts down to zero at the last bit of the frame
	assign reload  = (q.tmr == HEOF_TMR_RST);
	// no new connection while unlocked, late in frame or disabled
	assign conn_ok = q.locked && !q.zone && !q.port_dis;

	// one next-state process for the whole hub end
	always_comb
	begin
		next_q        = q;
		next_q.eof1   = hit1;
		next_q.eof2   = hit2;
		next_q.babble = 1'b0;

		// current-frame up counter with rollover detection
		if (lnk.sof)
		begin
			next_q.cur    = HEOF_TMR_RST;
			next_q.rolled = 1'b0;
		end
		else if (q.cur == roll_lim)
		begin
			next_q.rolled = 1'b1;
		end
		else
		begin
			next_q.cur = 16'(q.cur + 16'h0001);
		end

		// frame timer: sof after a clean interval loads and locks
		if (lnk.sof && q.seen_one && !q.rolled)
		begin
			next_q.tmr       = q.cur;
			next_q.nxt       = q.cur;
			next_q.locked    = 1'b1;
			next_q.miss      = HEOF_MISS_RST;
			next_q.sof_since = 1'b0;
		end
		else if (reload)
		begin
			// flywheel on the stored interval through missed sofs
			next_q.tmr       = q.nxt;
			next_q.sof_since = 1'b0;
			if (!q.sof_since && !lnk.sof && q.locked)
			begin
				if (q.miss == HEOF_MISS_MAX)
					next_q.locked = 1'b0;
				else
					next_q.miss = 2'(q.miss + 2'h1);
			end
		end
		else
		begin
			next_q.tmr = 16'(q.tmr - 16'h0001);
		end
		if (lnk.sof)
		begin
			next_q.seen_one  = 1'b1;
			next_q.sof_since = !(q.seen_one && !q.rolled) ? 1'b1
			                   : next_q.sof_since;
		end

		// late-frame zone from eof1 up to the frame end
		if (hit1)
			next_q.zone = 1'b1;
		else if (reload)
			next_q.zone = 1'b0;

		// connectivity; only line levels are used, never packet content
		if (!q.conn)
		begin
			if (i_dn_active && conn_ok)
				next_q.conn = 1'b1;
		end
		else if (lnk.hs)
		begin
			if (!i_dn_active && i_ebuf_empty)
				next_q.conn = 1'b0;
		end
		else if (!i_dn_active)
		begin
			next_q.conn = 1'b0;
		end

		// eof1: teardown, plus forced eop at full speed
		if (hit1)
		begin
			next_q.conn = 1'b0;
			if (!lnk.hs && (q.conn || (EOP_IDLE && !lnk.dn_busy)))
			begin
				next_q.eop_cnt = HEOF_EOP_BITS;
				next_q.eop     = 1'b1;
			end
		end
		else if (q.eop_cnt != HEOF_EOP_RST)
		begin
			// 4 bits from eof1 at 32 end well before upstream eof2
			next_q.eop_cnt = 3'(q.eop_cnt - 3'h1);
			next_q.eop     = (q.eop_cnt != 3'h1);
		end

		// eof2: a port still driving upstream is a babbler
		if (hit2 && (q.conn || i_dn_active))
		begin
			next_q.babble   = 1'b1;
			next_q.port_dis = 1'b1;
			next_q.conn     = 1'b0;
		end
		else if (i_port_reenable)
		begin
			// a disable in the same cycle wins over the reenable
			next_q.port_dis = 1'b0;
		end

		// reset or resume drops lock; lint-visible single path
		if (i_resume)
		begin
			next_q.locked    = 1'b0;
			next_q.seen_one  = 1'b0;
			next_q.sof_since = 1'b0;
			next_q.miss      = HEOF_MISS_RST;
			next_q.zone      = 1'b0;
			next_q.conn      = 1'b0;
		end
	end

	// register the whole state; the raw offsets other than the full-speed eof2 of 10 are multiples of 16,
	// so a bit clock divided by 16 could time them given a 16-step advance
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			q <= '0;
		end
		else
		begin
			q <= next_q;
		end
	end

	// outputs straight from state flops
	assign lnk.up_conn     = q.conn;
	assign lnk.up_eop      = q.eop;
	assign o_locked        = q.locked;
	assign o_eof1          = q.eof1;
	assign o_eof2          = q.eof2;
	assign o_conn          = q.conn;
	assign o_babble        = q.babble;
	assign o_port_disabled = q.port_dis;

endmodule : heof_hub // heof_hub
`default_nettype wire

/* rtl/heof_host.sv */
`timescale 1ns/1ps
`default_nettype none
module heof_host
	import heof_pkg::*;
#(
	parameter logic [15:0] FRAME_HS = HEOF_FRAME_HS,
	parameter logic [15:0] FRAME_FS = HEOF_FRAME_FS
)
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// link toward the hub
	heof_if.host             lnk,
	// transaction requests
	input  wire logic        i_hs,
	input  wire logic        i_req,
	input  wire logic [15:0] i_req_len,
	// status
	output logic             o_req_taken,
	output logic             o_req_refused,
	output logic             o_busy,
	output logic             o_trunc,
	output logic [15:0]      o_frame_bit
);

	typedef struct packed {
		logic [15:0] tmr;
		logic        sof;
		logic        hs;
		logic [15:0] busy_cnt;
		logic        busy;
		logic        taken;
		logic        refused;
		logic        trunc;
		logic        eop_q;
	} heof_host_s;

	heof_host_s q;
	heof_host_s next_q;

	logic [16:0] need;
	logic [15:0] eof1_pt;

	// last transaction must fit before the host's own eof1
	assign eof1_pt = q.hs ? HEOF_EOF1_HS : HEOF_EOF1_FS;
	assign need    = 17'(i_req_len) + 17'(eof1_pt);

	always_comb
	begin
		next_q         = q;
		next_q.sof     = 1'b0;
		next_q.taken   = 1'b0;
		next_q.refused = 1'b0;
		next_q.eop_q   = lnk.up_eop;
		// a forced eop truncates the packet; o_trunc pulses on its second bit
		next_q.trunc   = lnk.up_eop && !q.eop_q;

		// frame timer counts down, bit time zero is the last
		if (q.tmr == HEOF_TMR_RST)
		begin
			next_q.hs  = i_hs;
			next_q.tmr = 16'((i_hs ? FRAME_HS : FRAME_FS) - 16'h0001);
			next_q.sof = 1'b1;
		end
		else
		begin
			next_q.tmr = 16'(q.tmr - 16'h0001);
		end

		// start only what completes before eof1
		if (i_req && !q.busy && !q.sof)
		begin
			if (17'(q.tmr) > need && i_req_len != 16'h0000)
			begin
				next_q.taken    = 1'b1;
				next_q.busy     = 1'b1;
				next_q.busy_cnt = i_req_len;
			end
			else
			begin
				next_q.refused = 1'b1;
			end
		end
		else if (q.busy)
		begin
			next_q.busy_cnt = 16'(q.busy_cnt - 16'h0001);
			next_q.busy     = (q.busy_cnt != 16'h0001);
		end
	end

	// register the whole state
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			q <= '0;
		end
		else
		begin
			q <= next_q;
		end
	end

	// outputs straight from state flops
	assign lnk.sof       = q.sof;
	assign lnk.hs        = q.hs;
	assign lnk.dn_busy   = q.busy;
	assign o_req_taken   = q.taken;
	assign o_req_refused = q.refused;
	assign o_busy        = q.busy;
	assign o_trunc       = q.trunc;
	assign o_frame_bit   = q.tmr;

endmodule : heof_host // heof_host
`default_nettype wire

/* verification/heof_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module heof_checker
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// link signals
	input wire logic sof,
	input wire logic hs,
	input wire logic dn_busy,
	input wire logic up_conn,
	input wire logic up_eop
);
	logic [1:0] sof_seen;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	// frame starts since reset; resume is not visible here
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			sof_seen <= 2'h0;
		else if (sof && sof_seen != 2'h2)
			sof_seen <= sof_seen + 2'h1;
	end

	// forced eop: four bits, then released
	sequence s_eop_run;
		up_eop [*4] ##1 !up_eop;
	endsequence

	a_eop_four_bits:
		assert property ($rose(up_eop) |-> s_eop_run)
		else $error("eop length wrong");
	a_eop_quiet_tail:
		assert property ($fell(up_eop) |-> !up_eop [*8])
		else $error("eop restarted");
	a_eop_before_sof:
		assert property ($rose(up_eop) |-> ##[40:56] sof)
		else $error("eop misplaced");
	a_eop_drops_conn:
		assert property (up_eop |-> !up_conn)
		else $error("conn held in eop");
	a_hs_no_eop:
		assert property (hs |-> !up_eop)
		else $error("eop at high speed");
	a_sof_clear_eop:
		assert property (sof |-> !up_eop)
		else $error("eop over sof");
	a_conn_after_lock:
		assert property ($rose(up_conn) |-> sof_seen == 2'h2)
		else $error("conn before lock");
	a_eop_after_lock:
		assert property ($rose(up_eop) |-> sof_seen == 2'h2)
		else $error("eop before lock");

	c_busy_ends: cover property (dn_busy ##1 !dn_busy);
endmodule // heof_checker
`default_nettype wire

/* verification/tb_hub_eof_timing_points.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_hub_eof_timing_points import heof_pkg::*;;
	typedef struct packed {logic h; logic [15:0] w, n; logic [1:0] e;} heof_row_s;
	// mode, frame bit, length, {taken, refused}
	heof_row_s rows [5] = '{
		'{1'b1, 16'h02BC, 16'h008B, 2'h2},
		'{1'b1, 16'h02BC, 16'h008C, 2'h1},
		'{1'b0, 16'h0064, 16'h0043, 2'h2},
		'{1'b0, 16'h0064, 16'h0044, 2'h1},
		'{1'b0, 16'h0064, 16'h0000, 2'h1}};
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        hs = 1'b0;
	logic        req = 1'b0;
	logic [15:0] len = 16'h0000;
	logic        resume = 1'b0;
	logic        act = 1'b0;
	logic        ebuf = 1'b1;
	logic        reen = 1'b0;
	logic        taken, refused, busy, locked, eof1, eof2, conn, dis;
	logic        babble, trunc;
	logic        eop1, conn1, bab2;
	logic [15:0] fbit;
	int          num_errors = 0;
	int          check_count = 0;
	int          cnt = 0;
	int          t1 = 0;
	int          t2 = 0;
	int          ttr = 0;
	int          tmp;

	heof_if lnk ();
	heof_host #(.FRAME_HS(16'h07D0), .FRAME_FS(16'h0320)) heof_host_inst (
		.i_clk(clk), .i_rst_b(rst_b), .lnk(lnk), .i_hs(hs), .i_req(req),
		.i_req_len(len), .o_req_taken(taken), .o_req_refused(refused),
		.o_busy(busy), .o_trunc(trunc), .o_frame_bit(fbit));
	heof_hub heof_hub_inst (.i_clk(clk), .i_rst_b(rst_b), .lnk(lnk),
		.i_resume(resume), .i_dn_active(act), .i_ebuf_empty(ebuf),
		.i_port_reenable(reen), .o_locked(locked), .o_eof1(eof1),
		.o_eof2(eof2), .o_conn(conn), .o_babble(babble),
		.o_port_disabled(dis));
	heof_checker heof_checker_inst (.i_clk(clk), .i_rst_b(rst_b),
		.sof(lnk.sof), .hs(lnk.hs), .dn_busy(lnk.dn_busy),
		.up_conn(lnk.up_conn), .up_eop(lnk.up_eop));

	// 50 ns bit clock
	initial
		forever #25 clk = ~clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// hangs are cut by the cycle ceiling, not here
	task automatic nsof(input int n);
		repeat (n)
		begin
			@(negedge clk);
			while (lnk.sof !== 1'b1)
				@(negedge clk);
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// stamp eof pulses; settled values are read off the edge
	always @(negedge clk)
	begin
		cnt <= cnt + 1;
		if (eof1)
		begin
			t1 <= cnt;
			eop1 <= lnk.up_eop;
			conn1 <= conn;
		end
		if (eof2)
		begin
			t2 <= cnt;
			bab2 <= babble;
		end
		if (trunc)
			ttr <= cnt;
		if (cnt == 60000)
		begin
			num_errors++;
			close_out();
		end
	end

	// reset, lock, request table, then the awkward cases
	initial
	begin
		cyc(20);
		chk(16'({locked, conn, lnk.up_eop}), 16'h0000);
		chk(fbit, 16'h0000);
		rst_b = 1'b1;
		$display("end reset");
		nsof(1);
		cyc(2);
		chk(16'(locked), 16'h0000);
		nsof(1);
		cyc(2);
		chk(16'(locked), 16'h0001);
		$display("end lock");
		foreach (rows[i])
		begin
			hs = rows[i].h;
			nsof(2);
			while (fbit !== rows[i].w)
				@(negedge clk);
			req = 1'b1;
			len = rows[i].n;
			cyc(1);
			req = 1'b0;
			chk(16'({taken, refused}), 16'(rows[i].e));
			chk(16'({busy, lnk.dn_busy}), 16'({2{rows[i].e[1]}}));
			while (busy === 1'b1)
				@(negedge clk);
		end
		$display("end table");
		nsof(2);
		chk(16'(t2 - t1), HEOF_EOF1_FS - HEOF_EOF2_FS);
		chk(16'({eop1, conn1}), 16'h0002);
		chk(16'(ttr - t1), 16'h0001);
		chk(16'(cnt - t1 + 1), HEOF_EOF1_FS + HEOF_ADV_FS);
		// port left talking through eof2 gets disabled
		cyc(9);
		act = 1'b1;
		cyc(2);
		chk(16'({conn, lnk.up_conn}), 16'h0003);
		nsof(1);
		chk(16'({eop1, conn1, dis, conn}), 16'h000A);
		chk(16'(bab2), 16'h0001);
		act = 1'b0;
		reen = 1'b1;
		cyc(1);
		reen = 1'b0;
		cyc(1);
		chk(16'(dis), 16'h0000);
		$display("end full speed");
		hs = 1'b1;
		nsof(3);
		chk(16'(t2 - t1), HEOF_EOF1_HS - HEOF_EOF2_HS);
		chk(16'(cnt - t1 + 1), HEOF_EOF1_HS + HEOF_ADV_HS);
		chk(16'(locked), 16'h0001);
		cyc(9);
		ebuf = 1'b0;
		act = 1'b1;
		cyc(2);
		act = 1'b0;
		cyc(2);
		chk(16'(conn), 16'h0001);
		ebuf = 1'b1;
		cyc(2);
		chk(16'(conn), 16'h0000);
		act = 1'b1;
		while (eof1 !== 1'b1)
			@(negedge clk);
		chk(16'({conn, lnk.up_eop}), 16'h0000);
		act = 1'b0;
		nsof(1);
		chk(16'(dis), 16'h0000);
		chk(16'(bab2), 16'h0000);
		$display("end high speed");
		// resume drops lock; no eof action until two frame starts
		resume = 1'b1;
		cyc(1);
		resume = 1'b0;
		act = 1'b1;
		cyc(2);
		chk(16'({locked, conn}), 16'h0000);
		tmp = t1;
		nsof(1);
		chk(16'(t1 - tmp), 16'h0000);
		act = 1'b0;
		nsof(1);
		cyc(2);
		chk(16'(locked), 16'h0001);
		$display("end resume");
		close_out();
	end
endmodule // tb_hub_eof_timing_points
`default_nettype wire
